// file: logic/ubd_engine.sv
// ubd_engine: descriptor fetch, data move and write-back for one token at a time.
// assumes a same-clock serial engine, a granted RAM port with read data one
// cycle after grant, and firmware on AXI4-Lite.
`timescale 1ns/100ps
`include "ubd_map.svh"

module ubd_engine #(
    parameter int AW = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_tok_valid,
    input  wire ubd_pkg::ubd_tok_s i_tok,
    input  wire logic             i_rx_valid,
    input  wire logic [7:0]       i_rx_data,
    input  wire logic             i_rx_end,
    input  wire logic             i_rx_data1,
    input  wire logic             i_tx_ready,
    input  wire logic             i_tx_acked,
    input  wire logic             i_tx_timeout,
    output logic                  o_tx_valid,
    output logic [7:0]            o_tx_data,
    output logic                  o_tx_data1,
    output logic                  o_tx_end,
    output logic                  o_hs_valid,
    output ubd_pkg::ubd_hs_e      o_hs,
    output logic                  o_ram_req,
    output logic                  o_ram_we,
    output logic [9:0]            o_ram_addr,
    output logic [7:0]            o_ram_wdata,
    input  wire logic             i_ram_gnt,
    input  wire logic [7:0]       i_ram_rdata,
    output logic                  o_irq,
    input  wire logic [AW-1:0]    s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [AW-1:0]    s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready
);
    import ubd_pkg::*;

    // ------------------------------------------------------------------
    // descriptor location
    // ------------------------------------------------------------------
    function automatic logic [9:0] dsc_addr(input ubd_tok_s t);
        logic [3:0] idx;
        idx = t.ep + 4'h1;
        if (t.ep == 4'h0)
            idx = (t.pid == `UBD_PID_IN) ? 4'h0 : `UBD_IDX_EP0_OUT;
        else if (t.ep == `UBD_EP5)
            idx = `UBD_IDX_EP5 + {3'h0, t.odd};
        else if (t.ep == `UBD_EP6)
            idx = `UBD_IDX_EP6 + {3'h0, t.odd};
        dsc_addr = 10'({6'h0, idx} * `UBD_DSC_BYTES);
    endfunction

    ubd_state_e   state_q;
    ubd_tok_s     tok_q;
    logic [9:0]   dsc_q;
    logic [1:0]   step_q;
    logic [7:0]   ctrl_q;
    logic [7:0]   cnt_q;
    logic [7:0]   base_q;
    logic [7:0]   idx_q;
    logic         ovf_q;
    logic         ev_done_q;
    logic         ev_bto_q;
    logic         ev_buf_q;
    logic         en_q;
    logic [1:0]   inten_q;
    logic [1:0]   erren_q;
    logic         done_q;
    logic [1:0]   err_q;
    logic [5:0]   tokst_q;
    logic [7:0]   maxpkt_q;
    logic [AW-1:0] awaddr_q;
    logic [31:0]  wdata_q;
    logic         wstrb0_q;
    logic         wr_go;
    logic [9:0]   buf_addr;
    logic [7:0]   max_len;
    logic [7:0]   tx_len;

    // 16-byte aligned buffer, never more than 64 bytes used
    assign buf_addr = {base_q[5:0], `UBD_ALIGN_BITS};
    assign max_len  = (maxpkt_q > `UBD_MAX_PKT) ? `UBD_MAX_PKT : maxpkt_q;
    assign tx_len   = (cnt_q > max_len) ? max_len : cnt_q;
    assign wr_go    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // ------------------------------------------------------------------
    // transfer engine and RAM port
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        ev_done_q  <= 1'b0;
        ev_bto_q   <= 1'b0;
        ev_buf_q   <= 1'b0;
        o_hs_valid <= 1'b0;
        o_tx_end   <= 1'b0;
        if (!i_reset_n) begin
            state_q     <= S_IDLE;
            tok_q       <= '0;
            dsc_q       <= 10'h000;
            step_q      <= 2'h0;
            ctrl_q      <= 8'h00;
            cnt_q       <= 8'h00;
            base_q      <= 8'h00;
            idx_q       <= 8'h00;
            ovf_q       <= 1'b0;
            o_hs        <= UBD_HS_NONE;
            o_tx_valid  <= 1'b0;
            o_tx_data   <= 8'h00;
            o_tx_data1  <= 1'b0;
            o_ram_req   <= 1'b0;
            o_ram_we    <= 1'b0;
            o_ram_addr  <= 10'h000;
            o_ram_wdata <= 8'h00;
        end else begin
            unique case (state_q)
                S_IDLE: if (i_tok_valid && en_q) begin
                    tok_q      <= i_tok;
                    dsc_q      <= dsc_addr(i_tok);
                    o_ram_addr <= dsc_addr(i_tok);
                    o_ram_req  <= 1'b1;
                    o_ram_we   <= 1'b0;
                    step_q     <= 2'h0;
                    idx_q      <= 8'h00;
                    ovf_q      <= 1'b0;
                    state_q    <= S_FETCH;
                end
                S_FETCH: if (i_ram_gnt) begin
                    o_ram_req <= 1'b0;
                    state_q   <= S_FWAIT;
                end
                S_FWAIT: begin
                    unique case (step_q)
                        2'h0: ctrl_q <= i_ram_rdata;
                        2'h1: cnt_q  <= i_ram_rdata;
                        2'h2: base_q <= i_ram_rdata;
                        default: ;
                    endcase
                    if (step_q == 2'h2) begin
                        state_q <= S_CHECK;
                    end else begin
                        step_q     <= step_q + 2'h1;
                        o_ram_addr <= dsc_q + {8'h0, step_q + 2'h1};
                        o_ram_req  <= 1'b1;
                        state_q    <= S_FETCH;
                    end
                end
                S_CHECK: begin
                    o_tx_data1 <= ctrl_q[`UBD_TGL_BIT];
                    if (!ctrl_q[`UBD_OWN_BIT]) begin
                        o_hs_valid <= 1'b1;
                        o_hs       <= UBD_HS_NAK;
                        state_q    <= S_IDLE;
                    end else if (ctrl_q[`UBD_STALL_BIT]) begin
                        o_hs_valid <= 1'b1;
                        o_hs       <= UBD_HS_STALL;
                        state_q    <= S_IDLE;
                    end else if (tok_q.pid == `UBD_PID_IN) begin
                        state_q <= S_TX;
                    end else begin
                        state_q <= S_RX;
                    end
                end
                S_RX: begin
                    if (o_ram_req && i_ram_gnt)
                        o_ram_req <= 1'b0;
                    if (i_rx_valid) begin
                        if (o_ram_req && !i_ram_gnt) begin
                            ovf_q <= 1'b1;
                        end else if (idx_q < max_len) begin
                            o_ram_req   <= 1'b1;
                            o_ram_we    <= 1'b1;
                            o_ram_addr  <= buf_addr + {2'h0, idx_q};
                            o_ram_wdata <= i_rx_data;
                        end
                        if (idx_q != 8'hFF)
                            idx_q <= idx_q + 8'h01;
                    end
                    if (i_rx_end)
                        state_q <= S_RXEND;
                end
                S_RXEND: if (o_ram_req && !i_ram_gnt) begin
                    state_q <= S_RXEND;
                end else begin
                    o_ram_req  <= 1'b0;
                    o_hs_valid <= 1'b1;
                    if (ovf_q) begin
                        // a retry is expected, so the descriptor stays as it was
                        o_hs     <= tok_q.iso ? UBD_HS_NONE : UBD_HS_NAK;
                        ev_bto_q <= 1'b1;
                        state_q  <= S_IDLE;
                    end else if (ctrl_q[`UBD_SYNC_BIT] && !tok_q.iso &&
                                 i_rx_data1 != ctrl_q[`UBD_TGL_BIT]) begin
                        // repeated packet: acknowledge and drop
                        o_hs    <= UBD_HS_ACK;
                        state_q <= S_IDLE;
                    end else begin
                        o_hs     <= tok_q.iso ? UBD_HS_NONE : UBD_HS_ACK;
                        ev_buf_q <= idx_q > max_len;
                        cnt_q    <= (idx_q > max_len) ? max_len : idx_q;
                        step_q   <= 2'h0;
                        state_q  <= S_WB;
                    end
                end
                S_TX: if (idx_q == tx_len) begin
                    o_tx_end <= 1'b1;
                    state_q  <= S_TXACK;
                end else begin
                    o_ram_req  <= 1'b1;
                    o_ram_we   <= 1'b0;
                    o_ram_addr <= buf_addr + {2'h0, idx_q};
                    state_q    <= S_TXRD;
                end
                S_TXRD: if (i_ram_gnt) begin
                    o_ram_req <= 1'b0;
                    state_q   <= S_TXWT;
                end
                S_TXWT: begin
                    o_tx_valid <= 1'b1;
                    o_tx_data  <= i_ram_rdata;
                    state_q    <= S_TXOUT;
                end
                S_TXOUT: if (i_tx_ready) begin
                    o_tx_valid <= 1'b0;
                    idx_q      <= idx_q + 8'h01;
                    state_q    <= S_TX;
                end
                S_TXACK: if (i_tx_acked) begin
                    step_q  <= 2'h0;
                    state_q <= S_WB;
                end else if (i_tx_timeout) begin
                    state_q <= S_IDLE;
                end
                S_WB: begin
                    // count first, control byte last, so the holder flag drops last
                    o_ram_we <= 1'b1;
                    if (!o_ram_req) begin
                        o_ram_req <= 1'b1;
                        if (step_q == 2'h0) begin
                            o_ram_addr  <= dsc_q + `UBD_DSC_CNT;
                            o_ram_wdata <= cnt_q;
                        end else begin
                            o_ram_addr  <= dsc_q + `UBD_DSC_CTRL;
                            o_ram_wdata <= {1'b0, ctrl_q[`UBD_TGL_BIT], tok_q.pid,
                                            2'h0};
                        end
                    end else if (i_ram_gnt) begin
                        o_ram_req <= 1'b0;
                        step_q    <= step_q + 2'h1;
                        if (step_q == 2'h1) begin
                            ev_done_q <= 1'b1;
                            state_q   <= S_IDLE;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `UBD_RESP_OKAY;
            awaddr_q      <= '0;
            wdata_q       <= 32'h0000_0000;
            wstrb0_q      <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q      <= s_axi_wdata;
                wstrb0_q     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q > `UBD_REG_MAXPKT || awaddr_q[1:0] != 2'h0)
                                ? `UBD_RESP_DECERR : `UBD_RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `UBD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `UBD_RESP_OKAY;
            unique case (s_axi_araddr)
                `UBD_REG_CTRL:   s_axi_rdata <= {31'h0, en_q};
                `UBD_REG_INTEN:  s_axi_rdata <= {30'h0, inten_q};
                `UBD_REG_ERREN:  s_axi_rdata <= {30'h0, erren_q};
                `UBD_REG_INTST:  s_axi_rdata <= {30'h0, |err_q, done_q};
                `UBD_REG_ERRST:  s_axi_rdata <= {30'h0, err_q};
                `UBD_REG_TOKST:  s_axi_rdata <= {26'h0, tokst_q};
                `UBD_REG_MAXPKT: s_axi_rdata <= {24'h0, maxpkt_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `UBD_RESP_DECERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // control and status registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            en_q     <= 1'b0;
            inten_q  <= 2'h0;
            erren_q  <= 2'h0;
            maxpkt_q <= `UBD_MAX_PKT;
        end else if (wr_go && wstrb0_q) begin
            unique case (awaddr_q)
                `UBD_REG_CTRL:   en_q     <= wdata_q[0];
                `UBD_REG_INTEN:  inten_q  <= wdata_q[1:0];
                `UBD_REG_ERREN:  erren_q  <= wdata_q[1:0];
                `UBD_REG_MAXPKT: maxpkt_q <= wdata_q[7:0];
                default: ;
            endcase
        end
    end

    // sticky flags: write one to clear, a new event in the same cycle wins
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            done_q  <= 1'b0;
            err_q   <= 2'h0;
            tokst_q <= 6'h00;
            o_irq   <= 1'b0;
        end else begin
            if (wr_go && wstrb0_q && awaddr_q == `UBD_REG_INTST && wdata_q[`UBD_BIT_DONE])
                done_q <= 1'b0;
            if (wr_go && wstrb0_q && awaddr_q == `UBD_REG_ERRST)
                err_q <= err_q & ~wdata_q[1:0];
            if (ev_done_q) begin
                done_q  <= 1'b1;
                tokst_q <= {tok_q.ep, tok_q.pid != `UBD_PID_IN, tok_q.odd};
            end
            if (ev_bto_q && erren_q[`UBD_BIT_BTO])
                err_q[`UBD_BIT_BTO] <= 1'b1;
            if (ev_buf_q && erren_q[`UBD_BIT_BUFERR])
                err_q[`UBD_BIT_BUFERR] <= 1'b1;
            o_irq <= (done_q & inten_q[`UBD_BIT_DONE]) |
                     ((|err_q) & inten_q[`UBD_BIT_ERR]);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic wb_ctrl;
    assign wb_ctrl = state_q == S_WB && o_ram_req && step_q == 2'h1;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_check_owned;
        state_q == S_CHECK && ctrl_q[`UBD_OWN_BIT];
    endsequence
    sequence s_back_idle;
        ##1 o_hs_valid ##0 state_q == S_IDLE;
    endsequence

    property p_fetch_addr;
        state_q == S_IDLE && i_tok_valid && en_q |=> o_ram_req && !o_ram_we &&
            o_ram_addr == dsc_addr(tok_q);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("bad descriptor address");

    property p_own_nak;
        state_q == S_CHECK && !ctrl_q[`UBD_OWN_BIT] |-> s_back_idle ##0 o_hs == UBD_HS_NAK;
    endproperty
    a_own_nak: assert property (p_own_nak) else $error("unowned descriptor not refused");

    property p_stall;
        s_check_owned ##0 ctrl_q[`UBD_STALL_BIT] |-> s_back_idle ##0 o_hs == UBD_HS_STALL;
    endproperty
    a_stall: assert property (p_stall) else $error("stall not answered");

    property p_release;
        wb_ctrl |-> !o_ram_wdata[`UBD_OWN_BIT] && o_ram_addr == dsc_q && o_ram_we;
    endproperty
    a_release: assert property (p_release) else $error("holder flag not cleared");

    property p_toggle_pid;
        wb_ctrl |-> o_ram_wdata[`UBD_TGL_BIT] == ctrl_q[`UBD_TGL_BIT] &&
            o_ram_wdata[`UBD_PID_HI:`UBD_PID_LO] == tok_q.pid;
    endproperty
    a_toggle_pid: assert property (p_toggle_pid) else $error("control byte wrong");

    property p_clip;
        state_q == S_RX && o_ram_req && o_ram_we |->
            o_ram_addr - buf_addr < {2'h0, max_len};
    endproperty
    a_clip: assert property (p_clip) else $error("write beyond max packet");

    property p_base_kept;
        o_ram_req && o_ram_we |-> o_ram_addr != dsc_q + `UBD_DSC_BASE;
    endproperty
    a_base_kept: assert property (p_base_kept) else $error("buffer base written");

    property p_ovf_nowb;
        state_q == S_RXEND && ovf_q && !o_ram_req |=> state_q == S_IDLE && ev_bto_q
            ##1 !ev_done_q;
    endproperty
    a_ovf_nowb: assert property (p_ovf_nowb) else $error("overflow wrote back");

    property p_done;
        wb_ctrl && i_ram_gnt |=> ev_done_q ##1 done_q;
    endproperty
    a_done: assert property (p_done) else $error("token done not raised");
endmodule

// file: inc/ubd_map.svh
// ubd_map.svh: offsets, field positions and codes for the descriptor engine.
// assumes a 10-bit local packet RAM address and 8-bit descriptor bytes.
`ifndef UBD_MAP_SVH
`define UBD_MAP_SVH
// ----------------------------------------------------------------------
// descriptor layout
// ----------------------------------------------------------------------
`define UBD_DSC_BYTES   10'h003
`define UBD_DSC_CTRL    10'h000
`define UBD_DSC_CNT     10'h001
`define UBD_DSC_BASE    10'h002
`define UBD_OWN_BIT     7
`define UBD_TGL_BIT     6
`define UBD_PID_HI      5
`define UBD_PID_LO      2
`define UBD_SYNC_BIT    3
`define UBD_STALL_BIT   2
`define UBD_ALIGN_BITS  4'h0
`define UBD_IDX_EP0_OUT 4'h1
`define UBD_IDX_EP5     4'h6
`define UBD_IDX_EP6     4'h8
`define UBD_EP5         4'h5
`define UBD_EP6         4'h6
`define UBD_PID_OUT     4'h1
`define UBD_PID_IN      4'h9
`define UBD_PID_SETUP   4'hD
`define UBD_MAX_PKT     8'h40
// ----------------------------------------------------------------------
// register map (byte addresses) and bit positions
// ----------------------------------------------------------------------
`define UBD_REG_CTRL    8'h00
`define UBD_REG_INTEN   8'h04
`define UBD_REG_ERREN   8'h08
`define UBD_REG_INTST   8'h0C
`define UBD_REG_ERRST   8'h10
`define UBD_REG_TOKST   8'h14
`define UBD_REG_MAXPKT  8'h18
`define UBD_BIT_DONE    0
`define UBD_BIT_ERR     1
`define UBD_BIT_BTO     0
`define UBD_BIT_BUFERR  1
`define UBD_RESP_OKAY   2'h0
`define UBD_RESP_DECERR 2'h3
`endif

// file: inc/ubd_pkg.sv
// ubd_pkg: types shared by the descriptor engine and its surroundings.
// assumes the serial engine shares the engine clock.
package ubd_pkg;
    typedef struct packed {
        logic [3:0] pid;
        logic [3:0] ep;
        logic       odd;
        logic       iso;
    } ubd_tok_s;

    typedef enum logic [1:0] {
        UBD_HS_NONE,
        UBD_HS_ACK,
        UBD_HS_NAK,
        UBD_HS_STALL
    } ubd_hs_e;

    typedef enum logic [3:0] {
        S_IDLE, S_FETCH, S_FWAIT, S_CHECK, S_RX, S_RXEND,
        S_TX, S_TXRD, S_TXWT, S_TXOUT, S_TXACK, S_WB
    } ubd_state_e;
endpackage

// file: tb/ubd_host.sv
// ubd_host: packet RAM with grant port plus the host side of the serial engine.
// assumes one clock; i_slow halves the grant rate to stretch RAM latency.
`timescale 1ns/100ps
module ubd_host (
    input  wire logic       i_clk,
    input  wire logic       i_slow,
    input  wire logic       i_req,
    input  wire logic       i_we,
    input  wire logic [9:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_tx_end,
    output logic            o_gnt,
    output logic [7:0]      o_rdata,
    output logic            o_tx_ready,
    output logic            o_tx_acked
);
    logic [7:0] mem [1024];
    logic       ph = 1'b0;
    initial begin
        o_rdata = 8'h00;
        o_tx_acked = 1'b0;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    assign o_gnt = i_req & (ph | ~i_slow);
    assign o_tx_ready = 1'b1;
    // read data is only good the cycle after grant; otherwise it flips
    always @(posedge i_clk) begin
        ph <= ~ph;
        o_tx_acked <= i_tx_end;
        if (o_gnt && i_we) mem[i_addr] <= i_wdata;
        o_rdata <= (o_gnt && !i_we) ? mem[i_addr] : ~o_rdata;
    end
endmodule

// file: tb/ubd_engine_tb.sv
// ubd_engine_tb: table-driven token tests, then register checks.
// assumes grant-ready RAM in ubd_host and AXI4-Lite firmware access.
`timescale 1ns/100ps
module ubd_engine_tb;
    import ubd_pkg::*;
    typedef struct packed {
        logic [3:0] ep, pid; logic [7:0] ctl, n, ctl_x, cnt_x; ubd_hs_e hs;
    } ubd_row_s;
    logic i_clk = 0, i_reset_n = 0, i_tok_valid = 0, i_rx_valid = 0, i_rx_end = 0;
    logic i_rx_data1 = 0, i_tx_timeout = 0, i_tx_ready, i_tx_acked, i_ram_gnt, slow = 0;
    logic o_tx_valid, o_tx_data1, o_tx_end, o_hs_valid, o_ram_req, o_ram_we, o_irq;
    logic [7:0] i_rx_data = 0, o_tx_data, o_ram_wdata, i_ram_rdata;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [9:0] o_ram_addr, d;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    ubd_tok_s i_tok = '0;
    ubd_hs_e o_hs, hs_seen;
    int failures = 0, samples_checked = 0, tx_n = 0;
    ubd_row_s rows [7] = '{
        '{4'h1, 4'h1, 8'h80, 8'h03, 8'h04, 8'h03, UBD_HS_ACK},
        '{4'h0, 4'hD, 8'hC0, 8'h08, 8'h74, 8'h08, UBD_HS_ACK},
        '{4'h2, 4'h1, 8'h00, 8'h00, 8'h00, 8'h40, UBD_HS_NAK},
        '{4'h3, 4'h1, 8'h84, 8'h00, 8'h84, 8'h40, UBD_HS_STALL},
        '{4'h4, 4'h1, 8'h80, 8'h46, 8'h04, 8'h40, UBD_HS_ACK},
        '{4'h4, 4'h9, 8'h80, 8'h00, 8'h24, 8'h40, UBD_HS_NONE},
        '{4'h1, 4'h1, 8'hC8, 8'h02, 8'hC8, 8'h40, UBD_HS_ACK}};
    ubd_engine u_dut (.*);
    ubd_host u_host (.i_clk(i_clk), .i_slow(slow), .i_req(o_ram_req), .i_we(o_ram_we),
        .i_addr(o_ram_addr), .i_wdata(o_ram_wdata), .i_tx_end(o_tx_end), .o_gnt(i_ram_gnt),
        .o_rdata(i_ram_rdata), .o_tx_ready(i_tx_ready), .o_tx_acked(i_tx_acked));
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_hs_valid === 1'b1) hs_seen <= o_hs;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // the buffer holds 1..64 from the oversize row when the IN row reads it
    always @(posedge i_clk) if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
        chk(o_tx_data, 32'(tx_n + 1));
        tx_n <= tx_n + 1;
    end
    task axw(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
        do begin
            @(posedge i_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
    endtask
    task axr(input logic [7:0] a);
        @(posedge i_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge i_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        s_axi_rready <= 0;
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200us failures++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1;
        axw(8'h08, 32'h3);
        axw(8'h04, 32'h1);
        axw(8'h00, 32'h1);
        foreach (rows[r]) begin
            d = 10'(rows[r].ep == 0 ? (rows[r].pid == 9 ? 0 : 1) : rows[r].ep + 1) * 10'h003;
            slow <= r[0];
            hs_seen <= UBD_HS_NONE;
            // control byte last so the engine never sees a half-built entry
            u_host.mem[d + 1] = 8'h40;
            u_host.mem[d + 2] = 8'h02;
            u_host.mem[d] = rows[r].ctl;
            @(posedge i_clk);
            {i_tok_valid, i_tok} <= {1'b1, rows[r].pid, rows[r].ep, 2'b00};
            @(posedge i_clk);
            i_tok_valid <= 0;
            repeat (20) @(posedge i_clk);
            if (rows[r].hs == UBD_HS_ACK) begin
                for (int k = 0; k <= rows[r].n; k++) begin
                    {i_rx_valid, i_rx_end, i_rx_data} <=
                        {k < rows[r].n, k == rows[r].n, 8'(k + 1)};
                    @(posedge i_clk);
                    {i_rx_valid, i_rx_end} <= 2'h0;
                    repeat (5) @(posedge i_clk);
                end
                chk(u_host.mem[10'h01F + rows[r].cnt_x], rows[r].cnt_x);
                chk(u_host.mem[10'h020 + rows[r].cnt_x], 8'h00);
            end
            repeat (600) @(posedge i_clk);
            if (rows[r].hs != UBD_HS_NONE) chk(hs_seen, rows[r].hs);
            chk(u_host.mem[d], rows[r].ctl_x);
            chk(u_host.mem[d + 1], rows[r].cnt_x);
            chk(u_host.mem[d + 2], 8'h02);
            $display("row %0d done", r);
        end
        chk(tx_n, 32'h40);
        chk(o_irq, 1'b1);
        // back-to-back bytes at half grant rate must overrun the RAM port
        axw(8'h0C, 32'h1);
        slow <= 1;
        hs_seen <= UBD_HS_NONE;
        u_host.mem[10'h009] = 8'h80;
        @(posedge i_clk);
        {i_tok_valid, i_tok} <= {1'b1, 4'h1, 4'h2, 2'b00};
        @(posedge i_clk);
        i_tok_valid <= 0;
        repeat (20) @(posedge i_clk);
        for (int k = 0; k < 5; k++) begin
            {i_rx_valid, i_rx_end} <= {k < 4, k == 4};
            @(posedge i_clk);
        end
        {i_rx_valid, i_rx_end} <= 2'h0;
        repeat (20) @(posedge i_clk);
        chk(hs_seen, UBD_HS_NAK);
        chk(u_host.mem[10'h009], 8'h80);
        chk(o_irq, 1'b0);
        $display("overflow test done");
        axr(8'h10);
        chk(rd, 32'h3);
        axr(8'h0C);
        chk(rd, 32'h2);
        axr(8'h14);
        chk(rd, 32'h10);
        axr(8'h40);
        chk(s_axi_rresp, 2'h3);
        $display("register test done");
        i_reset_n <= 0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1;
        axr(8'h18);
        chk(rd, 32'h40);
        axr(8'h14);
        chk(rd, 32'h0);
        $display("reset test done");
        wrap_up();
    end
endmodule
